// ---- include/gdms_regs.vh ----
// register map, field layout and timing constants of the motion model selector
`ifndef GDMS_REGS_VH
`define GDMS_REGS_VH
// ==================================================
// register byte offsets
`define GDMS_MODEL_SEL_OFF 12'h000
`define GDMS_TIMING_OFF 12'h004
`define GDMS_VELOCITY_OFF 12'h008
`define GDMS_APPLIED_OFF 12'h00c
`define GDMS_DELAY_OFF 12'h010
`define GDMS_DELAY_ACT_OFF 12'h014
`define GDMS_SAWTOOTH_OFF 12'h018
`define GDMS_OFFSET_OFF 12'h01c
`define GDMS_RESET_OFF 12'h020
`define GDMS_STATUS_OFF 12'h024
// ==================================================
// model codes
`define GDMS_M_PORTABLE 3'h0
`define GDMS_M_STATIONARY 3'h1
`define GDMS_M_PEDESTRIAN 3'h2
`define GDMS_M_AUTOMOTIVE 3'h3
`define GDMS_M_SEA 3'h4
`define GDMS_M_AIR1G 3'h5
`define GDMS_M_AIR2G 3'h6
`define GDMS_M_AIR4G 3'h7
`define GDMS_SEL_AUTO 4'h8
`define GDMS_SEL_RESET 4'h0
// ==================================================
// timing mode field: 0 off, 1 on, 2 survey at power-on
`define GDMS_TMODE_OFF 2'h0
`define GDMS_TMODE_ON 2'h1
`define GDMS_TMODE_SURVEY 2'h2
// ==================================================
// velocity fields: speed in knots [15:0], climb rate ft/min [31:16]
`define GDMS_SPEED_LSB 0
`define GDMS_CLIMB_LSB 16
// ==================================================
// thresholds in knots and feet per minute
`define GDMS_KN_PED_UP 16'd2
`define GDMS_KN_PED_DN 16'd1
`define GDMS_KN_AUTO_UP 16'd10
`define GDMS_KN_AUTO_DN 16'd8
`define GDMS_KN_AIR1_UP 16'd60
`define GDMS_KN_AIR1_FORCE 16'd100
`define GDMS_KN_AIR1_DN 16'd50
`define GDMS_KN_AIR2_UP 16'd150
`define GDMS_KN_AIR2_DN 16'd130
`define GDMS_KN_AIR4_UP 16'd240
`define GDMS_KN_AIR4_DN 16'd210
`define GDMS_FPM_CLIMB 16'd400
// ==================================================
// delay offset limit in ns and receiver reset timing
`define GDMS_DELAY_MAX 16'sd32767
`define GDMS_DELAY_MIN -16'sd32767
`define GDMS_RST_PULSE_NS 1000
`define GDMS_LOCK_WAIT_S 60
`define GDMS_CLK_MHZ 100
`endif

// ---- src/gdms_auto_model.v ----
// automatic motion model chooser with hysteresis
`timescale 1ns/1ns
`default_nettype none
module gdms_auto_model (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // velocity and control
    input wire enable,
    input wire sample,
    input wire [15:0] speed,
    input wire [15:0] climb_abs,
    // chosen model
    output reg [2:0] model_reg
);
`include "gdms_regs.vh"
    reg [2:0] model_next;
    wire climb_ok;
    assign climb_ok = climb_abs > `GDMS_FPM_CLIMB;
    // ==================================================
    // one step per sample; thresholds held between entry and fallback
    always @* begin
        model_next = model_reg;
        case (model_reg)
            `GDMS_M_STATIONARY: begin
                if (speed > `GDMS_KN_PED_UP)
                    model_next = `GDMS_M_PEDESTRIAN;
            end
            `GDMS_M_PEDESTRIAN: begin
                if (speed > `GDMS_KN_AUTO_UP)
                    model_next = `GDMS_M_AUTOMOTIVE;
                else if (speed < `GDMS_KN_PED_DN)
                    model_next = `GDMS_M_STATIONARY;
            end
            `GDMS_M_AUTOMOTIVE: begin
                if ((speed > `GDMS_KN_AIR1_UP && climb_ok) || speed > `GDMS_KN_AIR1_FORCE)
                    model_next = `GDMS_M_AIR1G;
                else if (speed < `GDMS_KN_AUTO_DN)
                    model_next = `GDMS_M_PEDESTRIAN;
            end
            `GDMS_M_AIR1G: begin
                if (speed > `GDMS_KN_AIR2_UP)
                    model_next = `GDMS_M_AIR2G;
                else if (speed < `GDMS_KN_AIR1_DN)
                    model_next = `GDMS_M_AUTOMOTIVE;
            end
            `GDMS_M_AIR2G: begin
                if (speed > `GDMS_KN_AIR4_UP)
                    model_next = `GDMS_M_AIR4G;
                else if (speed < `GDMS_KN_AIR2_DN)
                    model_next = `GDMS_M_AIR1G;
            end
            `GDMS_M_AIR4G: begin
                if (speed < `GDMS_KN_AIR4_DN)
                    model_next = `GDMS_M_AIR2G;
            end
            default: model_next = `GDMS_M_STATIONARY;
        endcase
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            model_reg <= `GDMS_M_STATIONARY;
        else if (!enable)
            model_reg <= `GDMS_M_STATIONARY;
        else if (sample)
            model_reg <= model_next;
    end
endmodule // gdms_auto_model
`default_nettype wire

// ---- src/gdms_selector.v ----
// apb top of the motion model selector, delay offset and receiver reset
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module gdms_selector #(
    parameter RST_PULSE_CYC = (`GDMS_RST_PULSE_NS * `GDMS_CLK_MHZ + 999) / 1000,
    // a minute of cycles does not fit in 32 bits, so the count is 36 bits wide
    parameter [35:0] LOCK_WAIT_CYC = `GDMS_LOCK_WAIT_S * `GDMS_CLK_MHZ * 36'd1000000,
    parameter BLINK_CYC = 25000000
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // receiver side
    input wire [15:0] rx_sawtooth,
    input wire rx_sawtooth_valid,
    input wire [15:0] rx_pulse_offset,
    output reg [2:0] rx_model_reg,
    output reg rx_doppler_reg,
    output reg rx_reset_n_reg,
    output reg [15:0] rx_delay_reg,
    output reg [15:0] osc_steer_reg,
    output reg led_red_reg,
    // non-volatile store
    input wire [3:0] nv_model,
    output reg nv_write_reg,
    output reg [3:0] nv_data_reg
);
`include "gdms_regs.vh"
    // ==================================================
    // bus decode
    wire wr_en;
    wire rd_phase;
    wire addr_hit;
    assign wr_en = psel && penable && pwrite;
    assign rd_phase = psel && !pwrite;
    assign pready = 1'b1;
    assign addr_hit = (paddr == `GDMS_MODEL_SEL_OFF) || (paddr == `GDMS_TIMING_OFF) ||
                      (paddr == `GDMS_VELOCITY_OFF) || (paddr == `GDMS_APPLIED_OFF) ||
                      (paddr == `GDMS_DELAY_OFF) || (paddr == `GDMS_DELAY_ACT_OFF) ||
                      (paddr == `GDMS_SAWTOOTH_OFF) || (paddr == `GDMS_OFFSET_OFF) ||
                      (paddr == `GDMS_RESET_OFF) || (paddr == `GDMS_STATUS_OFF);
    assign pslverr = psel && penable && !addr_hit;
    // ==================================================
    // control registers
    reg [3:0] model_sel_reg;
    reg [1:0] tmode_reg;
    reg [15:0] speed_reg;
    reg [15:0] climb_reg;
    reg [15:0] delay_reg;
    reg [15:0] sawtooth_reg;
    reg vel_new_reg;
    reg nv_loaded_reg;
    wire [15:0] climb_abs;
    wire [15:0] wr_delay;
    wire signed [31:0] wr_delay_s;
    assign climb_abs = climb_reg[15] ? (~climb_reg + 16'h0001) : climb_reg;
    assign wr_delay_s = pwdata;
    // clamp on the full word, so out-of-range values never wrap into range
    assign wr_delay = (wr_delay_s < `GDMS_DELAY_MIN) ? `GDMS_DELAY_MIN :
                      (wr_delay_s > `GDMS_DELAY_MAX) ? `GDMS_DELAY_MAX : pwdata[15:0];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            model_sel_reg <= `GDMS_SEL_RESET;
            tmode_reg <= `GDMS_TMODE_OFF;
            speed_reg <= 16'h0000;
            climb_reg <= 16'h0000;
            delay_reg <= 16'h0000;
            vel_new_reg <= 1'b0;
            nv_loaded_reg <= 1'b0;
            nv_write_reg <= 1'b0;
            nv_data_reg <= 4'h0;
        end else begin
            nv_write_reg <= 1'b0;
            vel_new_reg <= 1'b0;
            if (!nv_loaded_reg) begin
                // stored selection restored once after reset
                nv_loaded_reg <= 1'b1;
                if (nv_model <= `GDMS_SEL_AUTO)
                    model_sel_reg <= nv_model;
            end
            if (wr_en) begin
                case (paddr)
                    `GDMS_MODEL_SEL_OFF: begin
                        if (pwdata[3:0] <= `GDMS_SEL_AUTO) begin
                            model_sel_reg <= pwdata[3:0];
                            nv_write_reg <= 1'b1;
                            nv_data_reg <= pwdata[3:0];
                        end
                    end
                    `GDMS_TIMING_OFF: begin
                        if (pwdata[1:0] != 2'h3)
                            tmode_reg <= pwdata[1:0];
                    end
                    `GDMS_VELOCITY_OFF: begin
                        speed_reg <= pwdata[`GDMS_SPEED_LSB +: 16];
                        climb_reg <= pwdata[`GDMS_CLIMB_LSB +: 16];
                        vel_new_reg <= 1'b1;
                    end
                    `GDMS_DELAY_OFF: delay_reg <= wr_delay;
                    default: delay_reg <= delay_reg;
                endcase
            end
        end
    end
    // ==================================================
    // sawtooth capture from receiver
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sawtooth_reg <= 16'h0000;
        else if (rx_sawtooth_valid)
            sawtooth_reg <= rx_sawtooth;
    end
    // ==================================================
    // automatic chooser
    wire timing_on;
    wire auto_on;
    wire [2:0] auto_model;
    assign timing_on = tmode_reg != `GDMS_TMODE_OFF;
    assign auto_on = (model_sel_reg == `GDMS_SEL_AUTO) && !timing_on;
    gdms_auto_model u_auto (
        .pclk(pclk),
        .presetn(presetn),
        .enable(auto_on),
        .sample(vel_new_reg),
        .speed(speed_reg),
        .climb_abs(climb_abs),
        .model_reg(auto_model)
    );
    // ==================================================
    // applied model
    reg [2:0] model_next;
    always @* begin
        if (timing_on)
            model_next = `GDMS_M_STATIONARY;
        else if (model_sel_reg == `GDMS_SEL_AUTO)
            model_next = auto_model;
        else
            model_next = model_sel_reg[2:0];
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_model_reg <= `GDMS_M_STATIONARY;
            rx_doppler_reg <= 1'b0;
        end else begin
            rx_model_reg <= model_next;
            rx_doppler_reg <= model_next >= `GDMS_M_AIR1G;
        end
    end
    // ==================================================
    // receiver reset sequencer: pulse, then lock wait with blinking led
    localparam S_IDLE = 3'b001;
    localparam S_PULSE = 3'b010;
    localparam S_WAIT = 3'b100;
    reg [2:0] state_reg;
    reg [35:0] cnt_reg;
    reg [31:0] blink_reg;
    wire rst_cmd;
    assign rst_cmd = wr_en && (paddr == `GDMS_RESET_OFF) && pwdata[0];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            cnt_reg <= 36'h000000000;
            blink_reg <= 32'h00000000;
            rx_reset_n_reg <= 1'b1;
            rx_delay_reg <= 16'h0000;
            led_red_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    led_red_reg <= 1'b0;
                    if (rst_cmd) begin
                        state_reg <= S_PULSE;
                        cnt_reg <= 36'h000000000;
                        rx_reset_n_reg <= 1'b0;
                        rx_delay_reg <= delay_reg;
                    end
                end
                S_PULSE: begin
                    cnt_reg <= cnt_reg + 36'h000000001;
                    if (cnt_reg >= RST_PULSE_CYC - 1) begin
                        state_reg <= S_WAIT;
                        cnt_reg <= 36'h000000000;
                        blink_reg <= 32'h00000000;
                        rx_reset_n_reg <= 1'b1;
                        led_red_reg <= 1'b1;
                    end
                end
                S_WAIT: begin
                    // led blinks until the lock wait ends
                    cnt_reg <= cnt_reg + 36'h000000001;
                    blink_reg <= blink_reg + 32'h00000001;
                    if (blink_reg >= BLINK_CYC - 1) begin
                        blink_reg <= 32'h00000000;
                        led_red_reg <= ~led_red_reg;
                    end
                    if (cnt_reg >= LOCK_WAIT_CYC - 1) begin
                        state_reg <= S_IDLE;
                        led_red_reg <= 1'b0;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
    // ==================================================
    // discipline: steer word moves one step toward zero offset per sample
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            osc_steer_reg <= 16'h8000;
        else if (rx_sawtooth_valid && rx_pulse_offset != 16'h0000) begin
            if (rx_pulse_offset[15])
                osc_steer_reg <= osc_steer_reg + 16'h0001;
            else
                osc_steer_reg <= osc_steer_reg - 16'h0001;
        end
    end
    // ==================================================
    // read mux, registered in the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_phase && !penable) begin
            case (paddr)
                `GDMS_MODEL_SEL_OFF: prdata <= {28'h0000000, model_sel_reg};
                `GDMS_TIMING_OFF: prdata <= {30'h00000000, tmode_reg};
                `GDMS_VELOCITY_OFF: prdata <= {climb_reg, speed_reg};
                `GDMS_APPLIED_OFF: prdata <= {29'h00000000, rx_model_reg};
                `GDMS_DELAY_OFF: prdata <= {{16{delay_reg[15]}}, delay_reg};
                `GDMS_DELAY_ACT_OFF: prdata <= {{16{rx_delay_reg[15]}}, rx_delay_reg};
                `GDMS_SAWTOOTH_OFF: prdata <= {{16{sawtooth_reg[15]}}, sawtooth_reg};
                `GDMS_OFFSET_OFF: prdata <= {{16{rx_pulse_offset[15]}}, rx_pulse_offset};
                `GDMS_STATUS_OFF: prdata <= {28'h0000000, rx_doppler_reg, led_red_reg,
                                             state_reg == S_IDLE, rx_reset_n_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule // gdms_selector
`default_nettype wire

// ---- testbench/gdms_selector_chk.sv ----
// concurrent checks on the motion model selector ports
`timescale 1ns/1ns
`default_nettype none
module gdms_selector_chk #(
    parameter RST_PULSE_CYC = 100
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // receiver side
    input wire logic [15:0] rx_sawtooth,
    input wire logic rx_sawtooth_valid,
    input wire logic [15:0] rx_pulse_offset,
    input wire logic [2:0] rx_model_reg,
    input wire logic rx_doppler_reg,
    input wire logic rx_reset_n_reg,
    input wire logic [15:0] rx_delay_reg,
    input wire logic [15:0] osc_steer_reg,
    input wire logic led_red_reg,
    // store
    input wire logic [3:0] nv_model,
    input wire logic nv_write_reg,
    input wire logic [3:0] nv_data_reg
);
    // ==========
    // mirror of the host writes and a count of receiver reset low cycles; the selector's own state is not visible here
    logic [3:0] sel_h;
    logic [1:0] tmode_h;
    logic [15:0] low_cnt;
    wire wr_acc = psel && penable && pwrite;
    wire wr_sel = wr_acc && paddr == 12'h000 && pwdata < 32'h9;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_h <= 4'h0;
            tmode_h <= 2'h0;
            low_cnt <= 16'h0;
        end else begin
            if (wr_sel) begin
                sel_h <= pwdata[3:0];
            end
            if (wr_acc && paddr == 12'h004 && pwdata < 32'h3) begin
                tmode_h <= pwdata[1:0];
            end
            low_cnt <= rx_reset_n_reg ? 16'h0 : low_cnt + 16'h1;
        end
    end
    // ==========
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sel_apply_a: assert property (wr_sel && !pwdata[3] && tmode_h == 2'h0 |-> ##[1:2]
        rx_model_reg == sel_h[2:0]) else $error("fixed code not applied");
    nv_store_a: assert property (wr_sel |=> nv_write_reg && nv_data_reg == sel_h)
        else $error("selection not stored");
    timing_force_a: assert property (tmode_h != 2'h0 |=> rx_model_reg == 3'h1)
        else $error("timing mode did not force stationary");
    doppler_map_a: assert property ($stable(rx_model_reg) |->
        rx_doppler_reg == (rx_model_reg >= 3'h5)) else $error("tracking kind wrong");
    steer_up_a: assert property (rx_sawtooth_valid && rx_pulse_offset[15] |=>
        osc_steer_reg == $past(osc_steer_reg) + 16'h1) else $error("steer not raised");
    steer_down_a: assert property (rx_sawtooth_valid && !rx_pulse_offset[15] &&
        rx_pulse_offset != 16'h0 |=> osc_steer_reg == $past(osc_steer_reg) - 16'h1)
        else $error("steer not lowered");
    delay_hold_a: assert property (!$stable(rx_delay_reg) |->
        !rx_reset_n_reg || !$past(rx_reset_n_reg)) else $error("delay moved outside reset");
    rst_width_a: assert property ($rose(rx_reset_n_reg) |-> low_cnt == RST_PULSE_CYC)
        else $error("receiver reset width wrong");
    led_wait_a: assert property (!$stable(led_red_reg) |-> rx_reset_n_reg)
        else $error("led moved during receiver reset");
endmodule // gdms_selector_chk
bind gdms_selector gdms_selector_chk #(.RST_PULSE_CYC(RST_PULSE_CYC)) chk_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_sawtooth,
    .rx_sawtooth_valid, .rx_pulse_offset, .rx_model_reg, .rx_doppler_reg, .rx_reset_n_reg,
    .rx_delay_reg, .osc_steer_reg, .led_red_reg, .nv_model, .nv_write_reg, .nv_data_reg);
`default_nettype wire

// ---- testbench/gdms_rx_model.sv ----
// receiver and non-volatile store facing the selector
`timescale 1ns/1ns
`default_nettype none
module gdms_rx_model #(
    parameter NV_INIT = 4'h0
) (
    // clock
    input wire logic pclk,
    // receiver side
    input wire logic rx_reset_n_reg,
    output var logic [15:0] rx_sawtooth = 16'h0,
    output var logic rx_sawtooth_valid = 1'b0,
    output var logic [15:0] rx_pulse_offset = 16'h0,
    // store
    input wire logic nv_write_reg,
    input wire logic [3:0] nv_data_reg,
    output var logic [3:0] nv_model = NV_INIT
);
    // ==========
    // store keeps its word while the selector is reset
    always @(posedge pclk) begin
        if (nv_write_reg) begin
            nv_model <= nv_data_reg;
        end
    end
    // ==========
    // one report; a receiver held in reset sends none, stale value is scrambled
    task report(input logic [15:0] saw, input logic [15:0] off);
        @(posedge pclk);
        rx_sawtooth <= saw;
        rx_pulse_offset <= off;
        rx_sawtooth_valid <= rx_reset_n_reg;
        @(posedge pclk);
        rx_sawtooth_valid <= 1'b0;
        rx_sawtooth <= ~saw;
    endtask
endmodule // gdms_rx_model
`default_nettype wire

// ---- testbench/gdms_selector_tb.sv ----
// self-checking bench for the motion model selector
`timescale 1ns/1ns
`default_nettype none
module gdms_selector_tb;
    // ==========
    // signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, rx_sawtooth_valid, rx_doppler_reg, rx_reset_n_reg, led_red_reg;
    wire nv_write_reg;
    wire [15:0] rx_sawtooth, rx_pulse_offset, rx_delay_reg, osc_steer_reg;
    wire [2:0] rx_model_reg;
    wire [3:0] nv_model, nv_data_reg;
    logic [31:0] q;
    logic e;
    int err_total = 0;
    int checked = 0;
    // speed, climb, expected applied code
    logic [35:0] tab [0:23] = '{36'h000200001, 36'h000300002, 36'h000100002, 36'h000000001,
        36'h000b00002, 36'h000b00003, 36'h000900003, 36'h000700002, 36'h000b00003,
        36'h005a00003, 36'h003c01913, 36'h005a01915, 36'h003700005, 36'h003100003,
        36'h006500005, 36'h009700006, 36'h008c00006, 36'h00f100007, 36'h00dc00007,
        36'h00d100006, 36'h008100005, 36'h003100003, 36'h003dfe6f5, 36'h003200005};
    always #5 pclk = ~pclk;
    // short counts keep the reset sequence brief
    gdms_selector #(.RST_PULSE_CYC(2), .LOCK_WAIT_CYC(50), .BLINK_CYC(5)) uut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_sawtooth,
        .rx_sawtooth_valid, .rx_pulse_offset, .rx_model_reg, .rx_doppler_reg, .rx_reset_n_reg,
        .rx_delay_reg, .osc_steer_reg, .led_red_reg, .nv_model, .nv_write_reg, .nv_data_reg);
    gdms_rx_model rx (.pclk, .rx_reset_n_reg, .rx_sawtooth, .rx_sawtooth_valid,
        .rx_pulse_offset, .nv_write_reg, .nv_data_reg, .nv_model);
    // ==========
    // bus and compare helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) err_total++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task rd16(input logic [11:0] a, input logic [15:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q[15:0], exp);
    endtask
    // ==========
    // scenarios
    task t_saw();
        rx.report(16'h0123, 16'hfff0);
        rd16(12'h018, 16'h0123);
        rd16(12'h01c, 16'hfff0);
        chk(osc_steer_reg, 32'h8001);
        rx.report(16'h0456, 16'h0010);
        rd16(12'h018, 16'h0456);
        chk(osc_steer_reg, 32'h8000);
    endtask
    task t_fixed();
        for (int c = 0; c < 8; c++) begin
            wr(12'h000, c);
            repeat (3) @(posedge pclk);
            rd(12'h00c, c);
            chk(rx_model_reg, c);
            chk(rx_doppler_reg, c >= 5);
        end
        wr(12'h000, 32'h9);
        rd(12'h000, 32'h7);
    endtask
    task t_timing();
        wr(12'h000, 32'h5);
        wr(12'h004, 32'h1);
        repeat (3) @(posedge pclk);
        rd(12'h00c, 32'h1);
        rd(12'h000, 32'h5);
        wr(12'h004, 32'h2);
        wr(12'h004, 32'h3);
        rd(12'h004, 32'h2);
        rd(12'h00c, 32'h1);
        wr(12'h004, 32'h0);
        repeat (3) @(posedge pclk);
        rd(12'h00c, 32'h5);
    endtask
    task t_auto();
        wr(12'h000, 32'h8);
        for (int i = 0; i < 24; i++) begin
            wr(12'h008, {tab[i][19:4], tab[i][35:20]});
            repeat (4) @(posedge pclk);
            rd(12'h00c, tab[i][3:0]);
        end
        rd(12'h000, 32'h8);
    endtask
    task t_delay();
        int n;
        int hi;
        n = 0;
        hi = 0;
        wr(12'h010, 32'hffff63c0);
        rd16(12'h010, 16'h8001);
        wr(12'h010, 32'h2d);
        rd16(12'h014, 16'h0);
        wr(12'h020, 32'h1);
        while (rx_reset_n_reg !== 1'b0 && n < 10) begin
            n++;
            @(posedge pclk);
        end
        chk(rx_delay_reg, 32'h2d);
        repeat (200) begin
            @(posedge pclk);
            if (led_red_reg === 1'b1) hi++;
        end
        chk(hi > 0, 1'b1);
        apb(1'b0, 12'h024, 32'h0);
        chk(q[1:0], 2'h3);
        rd16(12'h014, 16'h2d);
        rd(12'h020, 32'h0);
        apb(1'b0, 12'h030, 32'h0);
        chk(e, 1'b1);
    endtask
    task t_nv();
        wr(12'h000, 32'h6);
        repeat (2) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(12'h000, 32'h6);
        repeat (3) @(posedge pclk);
        rd(12'h00c, 32'h6);
    endtask
    // ==========
    // sequence, watchdog and verdict
    task end_of_test();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(12'h000, 32'h0);
        t_saw();
        t_fixed();
        t_timing();
        t_auto();
        t_delay();
        t_nv();
        end_of_test();
    end
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
endmodule // gdms_selector_tb
`default_nettype wire
